// ### pmic_regs_consts.svh
`ifndef PMIC_REGS_CONSTS_SVH
`define PMIC_REGS_CONSTS_SVH

// register offsets
`define ADDR_DEVICE_CODE_FIELD 8'h00
`define ADDR_VARIANT 8'h01
`define ADDR_SILICON_REVISION 8'h02
`define ADDR_SUMMARY 8'h06
`define ADDR_FAULT_STATUS 8'h08
`define ADDR_FAULT_MASK 8'h09
`define ADDR_FAULT_SENSE 8'h0a

// field positions
`define DEVCODE_LSB 0
`define DEVCODE_MSB 2
`define GROUP_LSB 3
`define GROUP_MSB 7
`define METAL_LSB 0
`define METAL_MSB 2
`define FULL_LSB 3
`define FULL_MSB 5
`define FAB_LSB 6
`define FAB_MSB 7
`define LOWSIDE_BIT 0

// summary bit positions
`define SUM_INPUT 0
`define SUM_BUCK1 1
`define SUM_BUCK2 2
`define SUM_BUCK3 3
`define SUM_LDO 4
`define SUM_BUTTON 5
`define SUM_TEMP 6
`define SUM_MISC 7

// reset values
`define MASK_RESET 1'b1
`define STATUS_RESET 1'b0
`define BYTE_ZERO 8'h00

// timing
`define CLK_PERIOD_NS 20
`define LS_DEBOUNCE_NS 30000
`define LS_DEBOUNCE_CYCLES \
  ((`LS_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LS_DEBOUNCE_CW 11

`endif

// ### pmic_regs_pkg.sv
package pmic_regs_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0]
  {
    sel_none,
    sel_device_code_field,
    sel_variant,
    sel_silicon_revision,
    sel_summary,
    sel_fault_status,
    sel_fault_mask,
    sel_fault_sense
  } reg_sel_t;

endpackage

// ### fault_debounce.sv
`timescale 1ns/10ps
`include "pmic_regs_consts.svh"

module fault_debounce
  import pmic_regs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_fault,
  output logic o_qualified
);

  localparam logic [`LS_DEBOUNCE_CW-1:0] hold_cycles =
    `LS_DEBOUNCE_CW'(`LS_DEBOUNCE_CYCLES);

  logic [`LS_DEBOUNCE_CW-1:0] count_reg;
  logic [`LS_DEBOUNCE_CW-1:0] count_next;
  logic qualified_reg;
  logic qualified_next;
  wire logic reached = (count_reg == hold_cycles);

  // count while the fault stands, restart when it drops
  assign count_next = !i_fault ? '0 :
    (reached ? count_reg : count_reg + `LS_DEBOUNCE_CW'(1));
  assign qualified_next = i_fault && reached; // see R13

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      count_reg <= '0;
      qualified_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      qualified_reg <= qualified_next;
    end
  end

  assign o_qualified = qualified_reg;

  ////////////////////////////////////////////////////////////////////////////
  // helper run length for checking
  logic [15:0] run_len;
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      run_len <= '0;
    else if (!i_fault)
      run_len <= '0;
    else if (run_len != 16'hffff)
      run_len <= run_len + 16'h0001;
  end

  property p_qual_needs_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_qualified |-> ($past(run_len) >= 16'(`LS_DEBOUNCE_CYCLES));
  endproperty
  a_qual_needs_hold: assert property (p_qual_needs_hold) // see R13
    else $error("qualified before debounce time");

endmodule

// ### sticky_flag.sv
`timescale 1ns/10ps
`include "pmic_regs_consts.svh"

module sticky_flag
  import pmic_regs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_set,
  input wire logic i_clear,
  input wire logic i_mask,
  output logic o_flag,
  output logic o_request
);

  logic flag_reg;
  logic flag_next;

  // set wins over a clear in the same cycle
  assign flag_next = i_set | (flag_reg & ~i_clear); // see R14 see R15

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      flag_reg <= `STATUS_RESET;
    else
      flag_reg <= flag_next;
  end

  assign o_flag = flag_reg;
  assign o_request = flag_reg & ~i_mask; // see R16

  property p_set_wins;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_set |=> o_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) // see R13
    else $error("set did not raise flag");

  property p_sticky;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_flag && !i_clear) |=> o_flag;
  endproperty
  a_sticky: assert property (p_sticky) // see R14
    else $error("flag dropped without clear");

endmodule

// ### pmic_id_irq_summary_regs.sv
`timescale 1ns/10ps
`include "pmic_regs_consts.svh"

// Summary of operation
// R1: three-bit fuse device code, read only
// R2: five-bit fuse part-group code above it
// R3: eight-bit fuse variant code, zero unprogrammed
// R4: metal and full-layer revision fields
// R5: top two bits give fabrication site
// R6: summary bit0 mirrors input-supply status
// R7: bits1-3 OR each buck's status bits
// R8: bit4 ORs all linear regulator status
// R9: bit5 ORs push-button status bits
// R10: bit6 ORs die temperature status bits
// R11: bit7 ORs remaining miscellaneous status bits
// R12: summary read only, resets zero, self-clearing
// R13: low-side bit set after debounce
// R14: low-side bit sticky until host clears
// R15: read or write-one clears it
// R16: unmasked set bit drives irq low
// R17: writes to read-only registers ignored
module pmic_id_irq_summary_regs
  import pmic_regs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_fuse_device_code,
  input wire logic [4:0] i_fuse_part_group,
  input wire logic [7:0] i_fuse_variant,
  input wire logic [2:0] i_fuse_metal_revision,
  input wire logic [2:0] i_fuse_full_mask_revision,
  input wire logic [1:0] i_fuse_fabrication_site,
  input wire logic i_input_supply_status,
  input wire logic [6:0] i_buck_one_other_status,
  input wire logic [7:0] i_buck_two_status,
  input wire logic [7:0] i_buck_three_status,
  input wire logic [7:0] i_linear_regulator_status,
  input wire logic [7:0] i_push_button_status,
  input wire logic [7:0] i_temperature_status,
  input wire logic [7:0] i_misc_status,
  input wire logic i_buck_one_lowside_fault,
  output logic o_irq_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic reg_sel_t decode(input logic [7:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    unique case (addr)
      `ADDR_DEVICE_CODE_FIELD: sel = sel_device_code_field;
      `ADDR_VARIANT: sel = sel_variant;
      `ADDR_SILICON_REVISION: sel = sel_silicon_revision;
      `ADDR_SUMMARY: sel = sel_summary;
      `ADDR_FAULT_STATUS: sel = sel_fault_status;
      `ADDR_FAULT_MASK: sel = sel_fault_mask;
      `ADDR_FAULT_SENSE: sel = sel_fault_sense;
      default: sel = sel_none;
    endcase
    return sel;
  endfunction

  wire reg_sel_t sel = decode(i_addr);
  wire logic wr_status = i_wr && (sel == sel_fault_status); // see R17
  wire logic wr_mask = i_wr && (sel == sel_fault_mask);
  wire logic rd_status = i_rd && (sel == sel_fault_status);

  ////////////////////////////////////////////////////////////////////////////
  // low-side current-limit fault path

  logic lowside_sense;
  logic buck_one_lowside_limit_status;
  logic lowside_request;
  logic mask_reg;
  logic mask_next;

  fault_debounce fault_debounce_inst
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_fault(i_buck_one_lowside_fault),
    .o_qualified(lowside_sense)
  );

  // a read or a written one clears the bit
  wire logic lowside_clear =
    rd_status || (wr_status && i_wdata[`LOWSIDE_BIT]); // see R15

  sticky_flag sticky_flag_inst
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_set(lowside_sense),
    .i_clear(lowside_clear),
    .i_mask(mask_reg),
    .o_flag(buck_one_lowside_limit_status),
    .o_request(lowside_request)
  );

  // mask is the only field that stores written data; status takes write-one clears
  assign mask_next = wr_mask ? i_wdata[`LOWSIDE_BIT] : mask_reg;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      mask_reg <= `MASK_RESET; // see R16
    else
      mask_reg <= mask_next;
  end

  // active low interrupt, low while request stands
  assign o_irq_out_n = ~lowside_request; // see R16

  ////////////////////////////////////////////////////////////////////////////
  // summary of categories

  wire logic input_supply_summary = i_input_supply_status; // see R6
  wire logic buck_one_summary =
    buck_one_lowside_limit_status | (|i_buck_one_other_status); // see R7
  wire logic buck_two_summary = |i_buck_two_status; // see R7
  wire logic buck_three_summary = |i_buck_three_status; // see R7
  wire logic linear_regulator_summary =
    |i_linear_regulator_status; // see R8
  wire logic push_button_summary = |i_push_button_status; // see R9
  wire logic temperature_summary = |i_temperature_status; // see R10
  wire logic misc_summary = |i_misc_status; // see R11

  // no storage, so each bit drops when its sources clear
  byte_t summary_value; // see R12
  always_comb
  begin
    summary_value = `BYTE_ZERO;
    summary_value[`SUM_INPUT] = input_supply_summary;
    summary_value[`SUM_BUCK1] = buck_one_summary;
    summary_value[`SUM_BUCK2] = buck_two_summary;
    summary_value[`SUM_BUCK3] = buck_three_summary;
    summary_value[`SUM_LDO] = linear_regulator_summary;
    summary_value[`SUM_BUTTON] = push_button_summary;
    summary_value[`SUM_TEMP] = temperature_summary;
    summary_value[`SUM_MISC] = misc_summary;
  end

  ////////////////////////////////////////////////////////////////////////////
  // identification fields, straight from fuses

  byte_t device_identification;
  byte_t silicon_revision;
  byte_t config_variant_code;

  always_comb
  begin
    device_identification = `BYTE_ZERO;
    device_identification[`DEVCODE_MSB:`DEVCODE_LSB] =
      i_fuse_device_code; // see R1
    device_identification[`GROUP_MSB:`GROUP_LSB] =
      i_fuse_part_group; // see R2
    silicon_revision = `BYTE_ZERO;
    silicon_revision[`METAL_MSB:`METAL_LSB] =
      i_fuse_metal_revision; // see R4
    silicon_revision[`FULL_MSB:`FULL_LSB] =
      i_fuse_full_mask_revision; // see R4
    silicon_revision[`FAB_MSB:`FAB_LSB] =
      i_fuse_fabrication_site; // see R5
    config_variant_code = i_fuse_variant; // see R3
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; writes elsewhere have no target

  byte_t status_byte;
  byte_t mask_byte;
  byte_t sense_byte;
  byte_t read_mux;
  byte_t rdata_reg;
  byte_t rdata_next;

  always_comb
  begin
    status_byte = `BYTE_ZERO;
    status_byte[`LOWSIDE_BIT] = buck_one_lowside_limit_status;
    mask_byte = `BYTE_ZERO;
    mask_byte[`LOWSIDE_BIT] = mask_reg;
    sense_byte = `BYTE_ZERO;
    sense_byte[`LOWSIDE_BIT] = lowside_sense;
  end

  always_comb
  begin
    read_mux = `BYTE_ZERO;
    unique case (sel)
      sel_none: read_mux = `BYTE_ZERO;
      sel_device_code_field: read_mux = device_identification;
      sel_variant: read_mux = config_variant_code;
      sel_silicon_revision: read_mux = silicon_revision;
      sel_summary: read_mux = summary_value;
      sel_fault_status: read_mux = status_byte;
      sel_fault_mask: read_mux = mask_byte;
      sel_fault_sense: read_mux = sense_byte;
    endcase
  end

  // data stand only in the cycle after the read strobe
  assign rdata_next = i_rd ? read_mux : `BYTE_ZERO;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      rdata_reg <= `BYTE_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  assign o_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_read_of(logic [7:0] addr);
    i_rd && (i_addr == addr);
  endsequence

  sequence s_status_clear_read;
    s_read_of(`ADDR_FAULT_STATUS) ##0 buck_one_lowside_limit_status
      ##0 !lowside_sense;
  endsequence

  property p_read_clears;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_status_clear_read |=>
        o_rdata[`LOWSIDE_BIT] && !buck_one_lowside_limit_status;
  endproperty
  a_read_clears: assert property (p_read_clears) // see R15
    else $error("read did not return and clear fault bit");

  property p_write_one_clears;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_wr && (i_addr == `ADDR_FAULT_STATUS) && i_wdata[`LOWSIDE_BIT]
        && !lowside_sense) |=> !buck_one_lowside_limit_status;
  endproperty
  a_write_one_clears: assert property (p_write_one_clears) // see R15
    else $error("write one did not clear fault bit");

  property p_sticky_top;
    @(posedge i_clock) disable iff (i_sys_rst)
      (buck_one_lowside_limit_status && !i_rd && !i_wr)
        |=> buck_one_lowside_limit_status;
  endproperty
  a_sticky_top: assert property (p_sticky_top) // see R14
    else $error("fault bit dropped with no host access");

  property p_sense_sets;
    @(posedge i_clock) disable iff (i_sys_rst)
      lowside_sense |=> buck_one_lowside_limit_status;
  endproperty
  a_sense_sets: assert property (p_sense_sets) // see R13
    else $error("debounced fault did not set status");

  property p_irq_level;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_irq_out_n == !(buck_one_lowside_limit_status && !mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) // see R16
    else $error("irq pin disagrees with status and mask");

  property p_mask_after_reset;
    @(posedge i_clock)
      $past(i_sys_rst) |-> (mask_reg && o_irq_out_n);
  endproperty
  a_mask_after_reset: assert property (p_mask_after_reset) // see R16
    else $error("mask not set after reset");

  property p_summary_read;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_read_of(`ADDR_SUMMARY) |=>
        (o_rdata[`SUM_INPUT] == $past(i_input_supply_status))
        && (o_rdata[`SUM_BUCK2] == $past(|i_buck_two_status))
        && (o_rdata[`SUM_BUCK3] == $past(|i_buck_three_status));
  endproperty
  a_summary_read: assert property (p_summary_read) // see R6 see R7
    else $error("summary supply or buck bits wrong");

  property p_summary_rest;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_read_of(`ADDR_SUMMARY) |=>
        (o_rdata[`SUM_LDO] == $past(|i_linear_regulator_status))
        && (o_rdata[`SUM_BUTTON] == $past(|i_push_button_status))
        && (o_rdata[`SUM_TEMP] == $past(|i_temperature_status))
        && (o_rdata[`SUM_MISC] == $past(|i_misc_status));
  endproperty
  a_summary_rest: assert property (p_summary_rest) // see R8 see R11
    else $error("summary regulator, button, temp or misc bit wrong");

  property p_summary_zero;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_read_of(`ADDR_SUMMARY) ##0 !buck_one_lowside_limit_status
        ##0 (i_buck_one_other_status == 7'h00)) |=> !o_rdata[`SUM_BUCK1];
  endproperty
  a_summary_zero: assert property (p_summary_zero) // see R12
    else $error("buck one summary stuck high");

  property p_id_read;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_read_of(`ADDR_DEVICE_CODE_FIELD) |=>
        o_rdata == $past({i_fuse_part_group, i_fuse_device_code});
  endproperty
  a_id_read: assert property (p_id_read) // see R1 see R2
    else $error("identification read wrong");

  property p_rev_read;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_read_of(`ADDR_SILICON_REVISION) |=>
        o_rdata == $past({i_fuse_fabrication_site,
          i_fuse_full_mask_revision, i_fuse_metal_revision});
  endproperty
  a_rev_read: assert property (p_rev_read) // see R4 see R5
    else $error("silicon revision read wrong");

  property p_variant_read;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_read_of(`ADDR_VARIANT) |=> o_rdata == $past(i_fuse_variant);
  endproperty
  a_variant_read: assert property (p_variant_read) // see R3
    else $error("variant read wrong");

  property p_ro_write_ignored;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_wr && (i_addr <= `ADDR_SUMMARY)) |=>
        $stable(mask_reg) && (o_rdata == `BYTE_ZERO);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) // see R17
    else $error("write to read-only register had an effect");

endmodule

// ### host_bus_model.sv
`timescale 1ns/10ps

module host_bus_model
(
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe; writing one to a latched bit clears it
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    o_addr <= addr;
    o_wdata <= data;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_wdata <= ~data;
  endtask

  // data stands only in the cycle after the strobe; a read also clears
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clock);
    o_addr <= addr;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1;
    data = i_rdata;
  endtask
endmodule

// ### pmic_id_irq_summary_regs_tb.sv
`timescale 1ns/10ps
`include "pmic_regs_consts.svh"

module pmic_id_irq_summary_regs_tb;
  import pmic_regs_pkg::*;

  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic o_irq_out_n;
  logic fault = 1'b0;
  logic [7:0] cat = 8'h00;
  logic [7:0] pat = 8'h00;
  int miscompares = 0;
  int checks = 0;
  // arbitrary fuse values, not tied to any real part
  localparam logic [2:0] DEV_CODE = 3'h5;
  localparam logic [4:0] GROUP = 5'h0a;
  localparam logic [7:0] VARIANT = 8'h3c;
  localparam logic [2:0] METAL = 3'h6;
  localparam logic [2:0] FULL = 3'h2;
  localparam logic [1:0] FAB = 2'h2;

  always #10 i_clock = ~i_clock;

  host_bus_model host_bus_model_inst
  (
    .i_clock(i_clock),
    .i_rdata(o_rdata),
    .o_addr(i_addr),
    .o_wdata(i_wdata),
    .o_wr(i_wr),
    .o_rd(i_rd)
  );

  pmic_id_irq_summary_regs pmic_id_irq_summary_regs_inst
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_fuse_device_code(DEV_CODE),
    .i_fuse_part_group(GROUP),
    .i_fuse_variant(VARIANT),
    .i_fuse_metal_revision(METAL),
    .i_fuse_full_mask_revision(FULL),
    .i_fuse_fabrication_site(FAB),
    .i_input_supply_status(cat[0]),
    .i_buck_one_other_status(cat[1] ? pat[6:0] : 7'h00),
    .i_buck_two_status(cat[2] ? pat : 8'h00),
    .i_buck_three_status(cat[3] ? pat : 8'h00),
    .i_linear_regulator_status(cat[4] ? pat : 8'h00),
    .i_push_button_status(cat[5] ? pat : 8'h00),
    .i_temperature_status(cat[6] ? pat : 8'h00),
    .i_misc_status(cat[7] ? pat : 8'h00),
    .i_buck_one_lowside_fault(fault),
    .o_irq_out_n(o_irq_out_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask

  task automatic rd_check(input string what, input logic [7:0] addr,
                          input logic [7:0] exp);
    logic [7:0] v;
    host_bus_model_inst.read_reg(addr, v);
    check(what, v, exp);
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    rd_check("summary", `ADDR_SUMMARY, 8'h00);
    rd_check("fault status", `ADDR_FAULT_STATUS, 8'h00);
    rd_check("fault mask", `ADDR_FAULT_MASK, 8'h01);
    check("irq", {7'h00, o_irq_out_n}, 8'h01);
  endtask

  task automatic test_identification();
    int k;
    for (k = 0; k < 2; k++)
    begin
      rd_check("id", `ADDR_DEVICE_CODE_FIELD, {GROUP, DEV_CODE});
      rd_check("variant", `ADDR_VARIANT, VARIANT);
      rd_check("rev", `ADDR_SILICON_REVISION, {FAB, FULL, METAL});
      rd_check("unmapped", 8'h05, 8'h00);
      host_bus_model_inst.write_reg(`ADDR_DEVICE_CODE_FIELD, 8'hff);
      host_bus_model_inst.write_reg(`ADDR_VARIANT, 8'ha5);
      host_bus_model_inst.write_reg(`ADDR_SILICON_REVISION, 8'h00);
      host_bus_model_inst.write_reg(`ADDR_SUMMARY, 8'hff);
    end
  endtask

  task automatic test_summary();
    int i;
    for (i = 0; i < 8; i++)
    begin
      @(posedge i_clock);
      cat <= 8'h01 << i;
      pat <= 8'h01 << (7 - i % 7);
      rd_check("summary one", `ADDR_SUMMARY, 8'h01 << i);
    end
    @(posedge i_clock);
    cat <= 8'hff;
    pat <= 8'hff;
    rd_check("summary all", `ADDR_SUMMARY, 8'hff);
    @(posedge i_clock);
    cat <= 8'h00;
    rd_check("summary cleared", `ADDR_SUMMARY, 8'h00);
  endtask

  task automatic hold_fault(input int cycles);
    @(posedge i_clock);
    fault <= 1'b1;
    repeat (cycles) @(posedge i_clock);
    fault <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask

  task automatic test_lowside_fault();
    hold_fault(`LS_DEBOUNCE_CYCLES - 20);
    rd_check("short fault", `ADDR_FAULT_STATUS, 8'h00);
    @(posedge i_clock);
    fault <= 1'b1;
    repeat (`LS_DEBOUNCE_CYCLES + 6) @(posedge i_clock);
    rd_check("sense on", `ADDR_FAULT_SENSE, 8'h01);
    rd_check("set wins", `ADDR_FAULT_STATUS, 8'h01);
    rd_check("still set", `ADDR_FAULT_STATUS, 8'h01);
    @(posedge i_clock);
    fault <= 1'b0;
    repeat (3) @(posedge i_clock);
    rd_check("sense off", `ADDR_FAULT_SENSE, 8'h00);
    check("irq masked", {7'h00, o_irq_out_n}, 8'h01);
    rd_check("summary buck", `ADDR_SUMMARY, 8'h02);
    host_bus_model_inst.write_reg(`ADDR_FAULT_MASK, 8'h00);
    #1;
    check("irq unmasked", {7'h00, o_irq_out_n}, 8'h00);
    host_bus_model_inst.write_reg(`ADDR_FAULT_STATUS, 8'hfe);
    rd_check("sticky", `ADDR_FAULT_STATUS, 8'h01);
    rd_check("read cleared", `ADDR_FAULT_STATUS, 8'h00);
    check("irq released", {7'h00, o_irq_out_n}, 8'h01);
    rd_check("summary back", `ADDR_SUMMARY, 8'h00);
    hold_fault(`LS_DEBOUNCE_CYCLES + 6);
    check("irq again", {7'h00, o_irq_out_n}, 8'h00);
    host_bus_model_inst.write_reg(`ADDR_FAULT_STATUS, 8'h01);
    #1;
    check("irq w1c", {7'h00, o_irq_out_n}, 8'h01);
    rd_check("w1c cleared", `ADDR_FAULT_STATUS, 8'h00);
  endtask

  task automatic test_mid_reset();
    hold_fault(`LS_DEBOUNCE_CYCLES + 6);
    check("irq before reset", {7'h00, o_irq_out_n}, 8'h00);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    check("irq after reset", {7'h00, o_irq_out_n}, 8'h01);
    rd_check("mask after reset", `ADDR_FAULT_MASK, 8'h01);
    rd_check("status after reset", `ADDR_FAULT_STATUS, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    test_reset_values();
    test_identification();
    test_summary();
    test_lowside_fault();
    test_mid_reset();
    report_and_stop();
  end

  initial
  begin
    repeat (100000) @(posedge i_clock);
    miscompares++;
    report_and_stop();
  end
endmodule
